// ==== tb/vpw_bus_irq_dma_control_tb_top.sv ====
// self-checking bench for the vpw interrupt, dma request and sleep control
`timescale 1ns/1ps
module vpw_bus_irq_dma_control_tb_top;
  logic       mclk = 1'b0;
  logic       reset = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       peripheral_enable = 1'b1;
  logic       peripheral_disable = 1'b0;
  logic       dma_suspend_option = 1'b0;
  logic       transmitting = 1'b0;
  logic       tx_timeout_flag = 1'b0;
  logic       frame_end_symbol = 1'b0;
  logic       break_symbol = 1'b0;
  logic [5:0] src = 6'h00;
  logic [7:0] rdata;
  logic [2:0] priority_level;
  logic       irq_req, irq_ack, rx_dma_req, tx_dma_req, rx_accept, rx_error_enable, rx_data_end_enable;
  logic       rx_dma_done, tx_dma_done, rx_dma_last, tx_dma_last;
  logic [1:0] codes [6] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
  int         failures = 0;
  int         n_checks = 0;

  always #50 mclk = ~mclk;

  vpw_bus_irq_dma_control u_dut (
    .mclk(mclk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .peripheral_enable(peripheral_enable), .peripheral_disable(peripheral_disable),
    .dma_suspend_option(dma_suspend_option), .transmitting(transmitting), .tx_timeout_flag(tx_timeout_flag),
    .frame_end_symbol(frame_end_symbol), .break_symbol(break_symbol), .error_flag(src[0]),
    .lost_arbitration_flag(src[1]), .data_end_min_flag(src[2]), .frame_end_min_flag(src[3]),
    .rx_full_flag(src[4]), .tx_ready_flag(src[5]), .rx_dma_done(rx_dma_done), .tx_dma_done(tx_dma_done),
    .rx_dma_last(rx_dma_last), .tx_dma_last(tx_dma_last), .irq_ack(irq_ack), .irq_req(irq_req),
    .priority_level(priority_level), .rx_dma_req(rx_dma_req), .tx_dma_req(tx_dma_req), .rx_accept(rx_accept),
    .rx_error_enable(rx_error_enable), .rx_data_end_enable(rx_data_end_enable)
  );

  vpw_host_model u_host (
    .mclk(mclk), .reset(reset), .irq_req(irq_req), .rx_dma_req(rx_dma_req), .tx_dma_req(tx_dma_req),
    .irq_ack(irq_ack), .rx_dma_done(rx_dma_done), .tx_dma_done(tx_dma_done), .rx_dma_last(rx_dma_last),
    .tx_dma_last(tx_dma_last)
  );

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  // read data live only in the cycle after the strobe, so look mid-cycle
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    check("rdata", rdata, exp);
    // return on a rising edge so that the caller drives its next inputs there
    @(posedge mclk);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic symbol(input bit brk);
    @(posedge mclk);
    frame_end_symbol <= !brk;
    break_symbol     <= brk;
    @(posedge mclk);
    frame_end_symbol <= 1'b0;
    break_symbol     <= 1'b0;
  endtask

  task automatic wait_ack();
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (irq_ack !== 1'b1 && n < 64);
    check("irq_ack", {7'h0, irq_ack}, 8'h01);
  endtask

  task automatic wait_dma(input bit tx);
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while ((tx ? tx_dma_req : rx_dma_req) !== 1'b0 && n < 64);
    check("dma_req_end", {7'h0, tx ? tx_dma_req : rx_dma_req}, 8'h00);
  endtask

  task automatic end_of_test();
    if (failures == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #(100 * 20000);
    failures++;
    end_of_test();
  end

  initial begin
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    rd_reg(8'hf8, 8'h00);
    rd_reg(8'hf9, 8'h10);
    rd_reg(8'hfa, 8'h00);
    rd_reg(8'hf7, 8'h00);
    wr_reg(8'hf8, 8'hff);
    rd_reg(8'hf8, 8'hf8);
    wr_reg(8'hf9, 8'he0);
    rd_reg(8'hf9, 8'hf0);
    check("priority_level", {5'h0, priority_level}, 8'h07);
    wr_reg(8'hfa, 8'hf6);
    src <= 6'h3f;
    cyc(3);
    check("irq_req", {7'h0, irq_req}, 8'h00);
    wr_reg(8'hfa, 8'h00);
    wr_reg(8'hf9, 8'h00);
    cyc(2);
    check("irq_req", {7'h0, irq_req}, 8'h00);
    rd_reg(8'hf9, 8'h10);
    check("rx_accept", {7'h0, rx_accept}, 8'h00);
    check("rx_error_enable", {7'h0, rx_error_enable}, 8'h00);
    check("rx_data_end_enable", {7'h0, rx_data_end_enable}, 8'h00);
    transmitting <= 1'b1;
    cyc(1);
    check("rx_error_enable", {7'h0, rx_error_enable}, 8'h01);
    check("rx_accept", {7'h0, rx_accept}, 8'h00);
    transmitting <= 1'b0;
    symbol(1'b0);
    rd_reg(8'hf9, 8'h00);
    check("rx_accept", {7'h0, rx_accept}, 8'h01);
    wr_reg(8'hf9, 8'h10);
    rd_reg(8'hf9, 8'h10);
    symbol(1'b1);
    rd_reg(8'hf9, 8'h00);
    tx_timeout_flag <= 1'b1;
    cyc(1);
    tx_timeout_flag <= 1'b0;
    rd_reg(8'hf9, 8'h10);
    symbol(1'b0);
    peripheral_enable <= 1'b0;
    cyc(2);
    peripheral_enable <= 1'b1;
    rd_reg(8'hf9, 8'h10);
    cyc(3);
    rd_reg(8'hf9, 8'h10);
    symbol(1'b0);
    wr_reg(8'hfa, 8'hf6);
    for (int i = 0; i < 6; i++) begin
      src <= 6'h3f << i;
      wait_ack();
      rd_reg(8'hf8, {5'h1f, codes[i], 1'b0});
    end
    for (int d = 0; d < 2; d++) begin
      wr_reg(8'hfa, d ? 8'h41 : 8'h28);
      src <= d ? 6'h20 : 6'h10;
      cyc(1);
      check("dma_req", {7'h0, d ? tx_dma_req : rx_dma_req}, 8'h01);
      check("irq_req", {7'h0, irq_req}, 8'h00);
      wait_dma(d[0]);
      src <= 6'h00;
      rd_reg(8'hfa, d ? 8'h40 : 8'h20);
      check("irq_req", {7'h0, irq_req}, 8'h01);
      rd_reg(8'hf9, d ? 8'h03 : 8'h02);
    end
    wr_reg(8'hf9, 8'h03);
    rd_reg(8'hf9, 8'h03);
    // software clears only the tx pending bit, which drops the request
    wr_reg(8'hf9, 8'h02);
    rd_reg(8'hf9, 8'h02);
    check("irq_req", {7'h0, irq_req}, 8'h00);
    wr_reg(8'hfa, 8'hff);
    peripheral_disable <= 1'b1;
    cyc(8);
    peripheral_disable <= 1'b0;
    rd_reg(8'hfa, 8'h00);
    rd_reg(8'hf9, 8'h10);
    wr_reg(8'hfa, 8'h88);
    dma_suspend_option <= 1'b1;
    src <= 6'h11;
    cyc(2);
    check("rx_dma_req", {7'h0, rx_dma_req}, 8'h00);
    check("irq_req", {7'h0, irq_req}, 8'h01);
    src <= 6'h10;
    cyc(1);
    check("rx_dma_req", {7'h0, rx_dma_req}, 8'h01);
    dma_suspend_option <= 1'b0;
    src <= 6'h11;
    cyc(1);
    check("rx_dma_req", {7'h0, rx_dma_req}, 8'h01);
    check("irq_req", {7'h0, irq_req}, 8'h00);
    end_of_test();
  end
endmodule // vpw_bus_irq_dma_control_tb_top

// ==== tb/vpw_host_model.sv ====
// host side model: interrupt acknowledge and dma controller
`timescale 1ns/1ps
module vpw_host_model #(
  parameter int ack_gap   = 3,
  parameter int dma_gap   = 2,
  parameter int block_len = 3
) (
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic irq_req,
  input  wire logic rx_dma_req,
  input  wire logic tx_dma_req,
  output logic      irq_ack = 1'b0,
  output logic      rx_dma_done = 1'b0,
  output logic      tx_dma_done = 1'b0,
  output logic      rx_dma_last = 1'b0,
  output logic      tx_dma_last = 1'b0
);
  int ack_cnt = 0;
  int rx_cnt  = 0;
  int tx_cnt  = 0;
  int rx_left = block_len;
  int tx_left = block_len;
  // dma_gap of at least 1 keeps a new transfer off the edge where the mask bit clears
  always @(posedge mclk) begin
    irq_ack     <= 1'b0;
    rx_dma_done <= 1'b0;
    tx_dma_done <= 1'b0;
    if (reset || !irq_req) begin
      ack_cnt <= ack_gap;
    end else if (ack_cnt == 0) begin
      irq_ack <= 1'b1;
      ack_cnt <= ack_gap;
    end else begin
      ack_cnt <= ack_cnt - 1;
    end
    if (reset || !rx_dma_req) begin
      rx_cnt <= dma_gap;
    end else if (rx_cnt == 0) begin
      rx_dma_done <= 1'b1;
      rx_dma_last <= (rx_left == 1);
      rx_left     <= (rx_left == 1) ? block_len : rx_left - 1;
      rx_cnt      <= dma_gap;
    end else begin
      rx_cnt <= rx_cnt - 1;
    end
    if (reset || !tx_dma_req) begin
      tx_cnt <= dma_gap;
    end else if (tx_cnt == 0) begin
      tx_dma_done <= 1'b1;
      tx_dma_last <= (tx_left == 1);
      tx_left     <= (tx_left == 1) ? block_len : tx_left - 1;
      tx_cnt      <= dma_gap;
    end else begin
      tx_cnt <= tx_cnt - 1;
    end
  end
endmodule // vpw_host_model

// ==== verilog/vpw_bus_irq_dma_control.sv ====
// interrupt, dma request and receive sleep control of the vpw protocol decoder
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
module vpw_bus_irq_dma_control (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       peripheral_enable,
  input  wire logic       peripheral_disable,
  input  wire logic       dma_suspend_option,
  input  wire logic       transmitting,
  input  wire logic       tx_timeout_flag,
  input  wire logic       frame_end_symbol,
  input  wire logic       break_symbol,
  input  wire logic       error_flag,
  input  wire logic       lost_arbitration_flag,
  input  wire logic       data_end_min_flag,
  input  wire logic       frame_end_min_flag,
  input  wire logic       rx_full_flag,
  input  wire logic       tx_ready_flag,
  input  wire logic       rx_dma_done,
  input  wire logic       tx_dma_done,
  input  wire logic       rx_dma_last,
  input  wire logic       tx_dma_last,
  input  wire logic       irq_ack,
  output logic            irq_req,
  output logic      [2:0] priority_level,
  output logic            rx_dma_req,
  output logic            tx_dma_req,
  output logic            rx_accept,
  output logic            rx_error_enable,
  output logic            rx_data_end_enable
);
  typedef struct packed {
    logic [4:0] vector_base;
    logic [1:0] source_code;
    logic [2:0] level;
    logic       rx_sleep;
    logic       rx_block_end_pending;
    logic       tx_block_end_pending;
    logic [7:0] mask;
    logic [2:0] dis_count;
    logic [7:0] rdata;
  } state_t;

  state_t cur;
  state_t next_cur;
  vpw_irq_pkg::serve_t serve;
  logic dis_long;
  logic dma_hold;
  logic rx_int_src;
  logic tx_int_src;
  logic err_int;
  logic end_int;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  assign dis_long = (cur.dis_count == vpw_irq_pkg::disable_hold_cycles);
  assign dma_hold = dma_suspend_option & (error_flag | lost_arbitration_flag);

  assign rx_dma_req = cur.mask[vpw_irq_pkg::pos_rxd_m] & rx_full_flag & ~dma_hold;
  assign tx_dma_req = cur.mask[vpw_irq_pkg::pos_txd_m] & tx_ready_flag & ~dma_hold;

  assign err_int = (error_flag & cur.mask[vpw_irq_pkg::pos_err_m])
                 | (lost_arbitration_flag & cur.mask[vpw_irq_pkg::pos_lost_arb_m]);
  assign end_int = (data_end_min_flag & cur.mask[vpw_irq_pkg::pos_data_end_m])
                 | (frame_end_min_flag & cur.mask[vpw_irq_pkg::pos_frame_end_m]);
  assign rx_int_src = cur.mask[vpw_irq_pkg::pos_rx_full_m]
                    & ((rx_full_flag & ~cur.mask[vpw_irq_pkg::pos_rxd_m]) | cur.rx_block_end_pending);
  assign tx_int_src = cur.mask[vpw_irq_pkg::pos_tx_ready_m]
                    & ((tx_ready_flag & ~cur.mask[vpw_irq_pkg::pos_txd_m]) | cur.tx_block_end_pending);

  always_comb begin
    serve = vpw_irq_pkg::srv_none;
    if (dma_suspend_option && err_int) begin
      serve = vpw_irq_pkg::srv_err;
    end else if (tx_dma_req) begin
      serve = vpw_irq_pkg::srv_txdma;
    end else if (rx_dma_req) begin
      serve = vpw_irq_pkg::srv_rxdma;
    end else if (err_int) begin
      serve = vpw_irq_pkg::srv_err;
    end else if (end_int) begin
      serve = vpw_irq_pkg::srv_end;
    end else if (rx_int_src) begin
      serve = vpw_irq_pkg::srv_rx;
    end else if (tx_int_src) begin
      serve = vpw_irq_pkg::srv_tx;
    end
  end

  assign irq_req = (serve inside {vpw_irq_pkg::srv_err, vpw_irq_pkg::srv_end,
                                  vpw_irq_pkg::srv_rx, vpw_irq_pkg::srv_tx})
                 && (cur.level != vpw_irq_pkg::level_never);
  assign priority_level = cur.level;

  assign rx_accept          = ~cur.rx_sleep;
  assign rx_error_enable    = ~cur.rx_sleep | transmitting;
  assign rx_data_end_enable = ~cur.rx_sleep;

  always_comb begin
    next_cur = cur;
    next_cur.rdata = 8'h00;
    if (peripheral_disable && !dis_long) begin
      next_cur.dis_count = cur.dis_count + 3'h1;
    end else if (!peripheral_disable) begin
      next_cur.dis_count = 3'h0;
    end

    if (irq_ack) begin
      case (serve)
        vpw_irq_pkg::srv_err: next_cur.source_code = vpw_irq_pkg::code_error;
        vpw_irq_pkg::srv_end: next_cur.source_code = vpw_irq_pkg::code_end;
        vpw_irq_pkg::srv_rx:  next_cur.source_code = vpw_irq_pkg::code_rx;
        vpw_irq_pkg::srv_tx:  next_cur.source_code = vpw_irq_pkg::code_tx;
        default:              next_cur.source_code = cur.source_code;
      endcase
    end

    if (wr) begin
      if (hit(addr, vpw_irq_pkg::off_vector)) begin
        next_cur.vector_base = wdata[7:3];
      end
      if (hit(addr, vpw_irq_pkg::off_priority)) begin
        next_cur.level = wdata[7:5];
        if (wdata[vpw_irq_pkg::pos_sleep]) begin
          next_cur.rx_sleep = 1'b1;
        end
        if (!wdata[vpw_irq_pkg::pos_rx_bep]) begin
          next_cur.rx_block_end_pending = 1'b0;
        end
        if (!wdata[vpw_irq_pkg::pos_tx_bep]) begin
          next_cur.tx_block_end_pending = 1'b0;
        end
      end
      if (hit(addr, vpw_irq_pkg::off_mask)) begin
        next_cur.mask = wdata;
      end
    end

    if (frame_end_symbol || break_symbol) begin
      next_cur.rx_sleep = 1'b0;
    end
    if (tx_timeout_flag) begin
      next_cur.rx_sleep = 1'b1;
    end
    if (!peripheral_enable || peripheral_disable) begin
      next_cur.rx_sleep = 1'b1;
    end

    // dma mask clears at block end
    if (rx_dma_done && rx_dma_last) begin
      next_cur.rx_block_end_pending = 1'b1;
      next_cur.mask[vpw_irq_pkg::pos_rxd_m] = 1'b0;
    end
    if (tx_dma_done && tx_dma_last) begin
      next_cur.tx_block_end_pending = 1'b1;
      next_cur.mask[vpw_irq_pkg::pos_txd_m] = 1'b0;
    end

    if (dis_long) begin
      next_cur.rx_block_end_pending = 1'b0;
      next_cur.tx_block_end_pending = 1'b0;
      next_cur.mask = vpw_irq_pkg::rst_mask;
    end

    if (rd) begin
      if (hit(addr, vpw_irq_pkg::off_vector)) begin
        next_cur.rdata = {cur.vector_base, cur.source_code, 1'b0};
      end else if (hit(addr, vpw_irq_pkg::off_priority)) begin
        next_cur.rdata = {cur.level, cur.rx_sleep, 2'b00,
                          cur.rx_block_end_pending, cur.tx_block_end_pending};
      end else if (hit(addr, vpw_irq_pkg::off_mask)) begin
        next_cur.rdata = cur.mask;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      cur.vector_base          <= vpw_irq_pkg::rst_vector_base;
      cur.source_code          <= vpw_irq_pkg::code_error;
      cur.level                <= vpw_irq_pkg::rst_priority[7:5];
      cur.rx_sleep             <= vpw_irq_pkg::rst_priority[4];
      cur.rx_block_end_pending <= vpw_irq_pkg::rst_priority[1];
      cur.tx_block_end_pending <= vpw_irq_pkg::rst_priority[0];
      cur.mask                 <= vpw_irq_pkg::rst_mask;
      cur.dis_count            <= 3'h0;
      cur.rdata                <= 8'h00;
    end else begin
      cur <= next_cur;
    end
  end

  assign rdata = cur.rdata;

  a_mask_cleared: assert property (@(posedge mclk) disable iff (reset)
    peripheral_disable [*7] |=> (cur.mask == 8'h00))
    else $error("mask not cleared after long disable");

  a_pending_cleared: assert property (@(posedge mclk) disable iff (reset)
    peripheral_disable [*7] |=> !cur.rx_block_end_pending && !cur.tx_block_end_pending)
    else $error("block end pending not cleared after long disable");

  a_rx_block_end: assert property (@(posedge mclk) disable iff (reset)
    rx_dma_done && rx_dma_last |=> !cur.mask[vpw_irq_pkg::pos_rxd_m]
      && (cur.rx_block_end_pending || $past(dis_long)))
    else $error("rx block end did not clear dma mask");

  a_rx_dma_gate: assert property (@(posedge mclk) disable iff (reset)
    !cur.mask[3] |-> !rx_dma_req)
    else $error("rx dma request while masked");

  a_dma_suspend: assert property (@(posedge mclk) disable iff (reset)
    dma_suspend_option && (error_flag || lost_arbitration_flag) |-> !rx_dma_req && !tx_dma_req)
    else $error("dma issued while suspended");

  a_sleep_forced: assert property (@(posedge mclk) disable iff (reset)
    !peripheral_enable |=> cur.rx_sleep)
    else $error("sleep not forced while disabled");

  a_sleep_sticky: assert property (@(posedge mclk) disable iff (reset)
    cur.rx_sleep && !frame_end_symbol && !break_symbol |=> cur.rx_sleep)
    else $error("sleep cleared without frame end");

  a_level_never: assert property (@(posedge mclk) disable iff (reset)
    cur.level == 3'h7 |-> !irq_req)
    else $error("interrupt requested at level seven");

  a_sleep_idle: assert property (@(posedge mclk) disable iff (reset)
    cur.rx_sleep && !transmitting |-> !rx_accept && !rx_error_enable && !rx_data_end_enable)
    else $error("receive not suppressed while asleep");

  a_vector_read: assert property (@(posedge mclk) disable iff (reset)
    rd && addr == 8'hf8 |=> rdata[2:1] == $past(cur.source_code) && !rdata[0])
    else $error("vector source code misread");

  a_tx_block_end: assert property (@(posedge mclk) disable iff (reset)
    tx_dma_done && tx_dma_last |=> !cur.mask[vpw_irq_pkg::pos_txd_m]
      && (cur.tx_block_end_pending || $past(dis_long)))
    else $error("tx block end did not clear dma mask");

  a_tx_dma_gate: assert property (@(posedge mclk) disable iff (reset)
    !cur.mask[vpw_irq_pkg::pos_txd_m] |-> !tx_dma_req)
    else $error("tx dma request while masked");

  a_rx_full_dma: assert property (@(posedge mclk) disable iff (reset)
    cur.mask[vpw_irq_pkg::pos_rxd_m] && rx_full_flag && !dma_suspend_option |-> rx_dma_req)
    else $error("rx full did not request dma");

  a_tx_ready_dma: assert property (@(posedge mclk) disable iff (reset)
    cur.mask[vpw_irq_pkg::pos_txd_m] && tx_ready_flag && !dma_suspend_option |-> tx_dma_req)
    else $error("tx ready did not request dma");

  a_dma_first: assert property (@(posedge mclk) disable iff (reset)
    rx_dma_req || tx_dma_req |-> !irq_req)
    else $error("interrupt requested above a dma request");

  a_error_first: assert property (@(posedge mclk) disable iff (reset)
    dma_suspend_option && err_int && cur.level != vpw_irq_pkg::level_never
      |-> irq_req && serve == vpw_irq_pkg::srv_err)
    else $error("error source not served first under suspend");

  a_rx_pending_irq: assert property (@(posedge mclk) disable iff (reset)
    cur.rx_block_end_pending && cur.mask[vpw_irq_pkg::pos_rx_full_m] && cur.level != vpw_irq_pkg::level_never
      && !rx_dma_req && !tx_dma_req |-> irq_req)
    else $error("rx block end pending without interrupt");

  a_tx_pending_irq: assert property (@(posedge mclk) disable iff (reset)
    cur.tx_block_end_pending && cur.mask[vpw_irq_pkg::pos_tx_ready_m] && cur.level != vpw_irq_pkg::level_never
      && !rx_dma_req && !tx_dma_req |-> irq_req)
    else $error("tx block end pending without interrupt");

  a_pending_zero: assert property (@(posedge mclk) disable iff (reset)
    wr && hit(addr, vpw_irq_pkg::off_priority) && !wdata[vpw_irq_pkg::pos_rx_bep]
      && !(rx_dma_done && rx_dma_last) |=> !cur.rx_block_end_pending)
    else $error("zero write did not clear rx pending");

  a_pending_one: assert property (@(posedge mclk) disable iff (reset)
    wr && hit(addr, vpw_irq_pkg::off_priority) && wdata[vpw_irq_pkg::pos_tx_bep] && !cur.tx_block_end_pending
      && !(tx_dma_done && tx_dma_last) |=> !cur.tx_block_end_pending)
    else $error("one write set tx pending");

  a_sleep_timeout: assert property (@(posedge mclk) disable iff (reset)
    tx_timeout_flag |=> cur.rx_sleep)
    else $error("sleep not set on timeout");

  a_sleep_wake: assert property (@(posedge mclk) disable iff (reset)
    (frame_end_symbol || break_symbol) && peripheral_enable && !peripheral_disable && !tx_timeout_flag
      |=> !cur.rx_sleep)
    else $error("sleep not cleared by frame end");

  a_sleep_write: assert property (@(posedge mclk) disable iff (reset)
    wr && hit(addr, vpw_irq_pkg::off_priority) && wdata[vpw_irq_pkg::pos_sleep]
      && !frame_end_symbol && !break_symbol |=> cur.rx_sleep)
    else $error("sleep not set by software");

  a_mask_silent: assert property (@(posedge mclk) disable iff (reset)
    cur.mask == vpw_irq_pkg::rst_mask |-> !irq_req)
    else $error("interrupt requested with all sources masked");

  a_vector_hold: assert property (@(posedge mclk) disable iff (reset)
    !(wr && hit(addr, vpw_irq_pkg::off_vector)) |=> $stable(cur.vector_base))
    else $error("vector base changed without a write");

  a_code_hold: assert property (@(posedge mclk) disable iff (reset)
    !irq_ack |=> $stable(cur.source_code))
    else $error("source code changed without acknowledge");

  a_code_latch: assert property (@(posedge mclk) disable iff (reset)
    irq_ack && serve == vpw_irq_pkg::srv_end |=> cur.source_code == vpw_irq_pkg::code_end)
    else $error("frame end source code not latched");

  a_sleep_transmit: assert property (@(posedge mclk) disable iff (reset)
    cur.rx_sleep && transmitting |-> !rx_accept && rx_error_enable && !rx_data_end_enable)
    else $error("receive gating wrong while asleep and transmitting");

  a_awake_open: assert property (@(posedge mclk) disable iff (reset)
    !cur.rx_sleep |-> rx_accept && rx_error_enable && rx_data_end_enable)
    else $error("receive blocked while awake");

  a_level_hold: assert property (@(posedge mclk) disable iff (reset)
    !(wr && hit(addr, vpw_irq_pkg::off_priority)) |=> $stable(cur.level))
    else $error("priority level changed without a write");

endmodule // vpw_bus_irq_dma_control

// ==== verilog/vpw_irq_pkg.sv ====
// constants for the vpw bus interrupt, dma request and receive sleep control
// Summary of operation
// - vector register bits 7:3 are software read/write base; bit 0 reserved.
// - vector bits 2:1 read the encoded source of the serviced request.
// - priority level in bits 7:5; zero highest, seven never served.
// - without suspend: tx dma, rx dma, error, data/frame end, rx full, tx ready.
// - with suspend the error/lost arbitration source ranks above both dma requests.
// - software writing one to sleep blocks receive data until a frame end or break symbol.
// - asleep and idle: no rx byte, no rx full, overflow, crc, frame, bit, data-end flags.
// - asleep and transmitting: no rx byte, rx full, overflow; errors still reported.
// - sleep ignores zero writes; set on reset or timeout; stays set until frame end or break.
// - sleep clears on frame end or break; forced set while disabled.
// - rx block end pending set after last rx dma; interrupts only with rx-full mask.
// - tx block end pending set after last tx dma; interrupts only with tx-ready mask.
// - block end pending bits take only zero writes, which cancel the request.
// - both block end pending bits clear after disable held six clocks.
// - dma mask bit clears when its counter reaches zero, with pending bit set.
// - a pending source requests an interrupt only when its mask bit is one.
// - mask register forced to zero once disable held six clocks.
// - mask bits high to low: error, tx-ready, rx-full, lost-arb, rx-dma, data-end, frame-end, tx-dma.
// - rx dma mask zero: rx full interrupts; one: rx full requests dma instead.
// - tx dma mask zero: tx ready interrupts; one: tx ready requests dma instead.
// - with suspend option, all dma held off while error or lost arbitration set.
package vpw_irq_pkg;
  localparam logic [7:0] off_vector   = 8'hf8;
  localparam logic [7:0] off_priority = 8'hf9;
  localparam logic [7:0] off_mask     = 8'hfa;
  localparam logic [7:0] rst_priority = 8'h10;
  localparam logic [7:0] rst_mask     = 8'h00;
  localparam logic [4:0] rst_vector_base = 5'h00;
  localparam int pos_sleep   = 4;
  localparam int pos_rx_bep  = 1;
  localparam int pos_tx_bep  = 0;
  localparam int pos_err_m       = 7;
  localparam int pos_tx_ready_m  = 6;
  localparam int pos_rx_full_m   = 5;
  localparam int pos_lost_arb_m  = 4;
  localparam int pos_rxd_m       = 3;
  localparam int pos_data_end_m  = 2;
  localparam int pos_frame_end_m = 1;
  localparam int pos_txd_m       = 0;
  localparam logic [2:0] disable_hold_cycles = 3'h6;
  localparam logic [1:0] code_error = 2'h0;
  localparam logic [1:0] code_end   = 2'h1;
  localparam logic [1:0] code_rx    = 2'h2;
  localparam logic [1:0] code_tx    = 2'h3;
  localparam logic [2:0] level_never = 3'h7;
  typedef enum logic [6:0] {
    srv_none  = 7'h01,
    srv_txdma = 7'h02,
    srv_rxdma = 7'h04,
    srv_err   = 7'h08,
    srv_end   = 7'h10,
    srv_rx    = 7'h20,
    srv_tx    = 7'h40
  } serve_t;
endpackage
